// file: verilog/flash_cfg_pkg.sv
// Package with constants, types and layouts for the flash base and configuration block
package flash_cfg_pkg;

    // Base register location in control-register space
    localparam logic [11:0] FBAR_CTL_ADDR    = 12'hC04;

    // Base register field positions
    localparam int          FBAR_BA_LO       = 19;
    localparam int          FBAR_WP_BIT      = 8;
    localparam int          FBAR_BDE_BIT     = 7;
    localparam int          FBAR_MASK_CPU    = 5;
    localparam int          FBAR_MASK_SC     = 4;
    localparam int          FBAR_MASK_SD     = 3;
    localparam int          FBAR_MASK_UC     = 2;
    localparam int          FBAR_MASK_UD     = 1;
    localparam int          FBAR_V_BIT       = 0;
    localparam logic [31:0] FBAR_WMASK       = 32'hFFF8_01BF;
    localparam logic [31:0] FBAR_RESET       = 32'h0000_0000;

    // Configuration field layout inside the array
    localparam logic [18:0] CFG_BASE_OFS     = 19'h0_0400;
    localparam int          CFG_FIELD_BYTES  = 24;
    localparam logic [2:0]  CFG_WORDS        = 3'h6;
    localparam logic [2:0]  CFG_KEY_HI_IDX   = 3'h0;
    localparam logic [2:0]  CFG_KEY_LO_IDX   = 3'h1;
    localparam logic [2:0]  CFG_PROT_IDX     = 3'h2;
    localparam logic [2:0]  CFG_SACC_IDX     = 3'h3;
    localparam logic [2:0]  CFG_DACC_IDX     = 3'h4;
    localparam logic [2:0]  CFG_SEC_IDX      = 3'h5;

    // Security state code in the security longword
    localparam int          SEC_STATE_HI     = 31;
    localparam int          SEC_STATE_LO     = 30;
    localparam logic [1:0]  SEC_SECURED_CODE = 2'h2;

    // Boot strap codes
    localparam logic [2:0]  BOOT_SINGLE_CHIP = 3'h6;
    localparam logic [2:0]  BOOT_MASTER      = 3'h7;
    localparam logic [1:0]  BOOT_INTERNAL    = 2'h0;

    // Backdoor alias and read timing
    localparam logic [31:0] BACKDOOR_OFS     = 32'h0400_0000;
    localparam logic [2:0]  RD_CYCLES        = 3'h2;
    localparam logic [2:0]  BD_EXTRA_CYCLES  = 3'h2;

    // Boot sequence states, Gray coded along the path
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_LOAD  = 2'b01,
        ST_APPLY = 2'b11,
        ST_RUN   = 2'b10
    } boot_state_t;

    // Access space codes
    typedef enum logic [2:0] {
        SP_CPU = 3'h0,
        SP_SC  = 3'h1,
        SP_SD  = 3'h2,
        SP_UC  = 3'h3,
        SP_UD  = 3'h4
    } space_t;

    // Access request bundle
    typedef struct packed {
        logic        req;
        logic        write;
        logic        core;
        space_t      space;
        logic [31:0] addr;
    } access_req_t;

    // Debug port request bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dbg_req_t;

    // Values applied from the configuration field
    typedef struct packed {
        logic [63:0] key;
        logic [31:0] prot;
        logic [31:0] sacc;
        logic [31:0] dacc;
        logic [31:0] sec;
    } cfg_vals_t;

endpackage : flash_cfg_pkg

// file: verilog/cfg_store.sv
// Small word store holding the configuration field image
`timescale 1ns/1ns
module cfg_store
    import flash_cfg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [2:0]  raddr,
    output logic      [31:0] rdata_q
);

    logic [7:0][31:0] mem_q;

    // One write port per entry
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_word
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= 32'h0000_0000;
                end else if (clk_en && we && (waddr == 3'(gi))) begin
                    mem_q[gi] <= wdata;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_q <= mem_q[raddr];
        end
    end

endmodule : cfg_store

// file: verilog/flash_base_config.sv
// Flash base address register, boot validity and configuration field loader
//
// Summary of operation
// R1: A 24-byte array region sets protection, access and security out of reset.
// R2: Backdoor comparison key sits at array offsets 0x400 to 0x407.
// R3: Sector protection word is read from array offsets 0x408 to 0x40B.
// R4: Supervisor/user restriction word is read from offsets 0x40C to 0x40F.
// R5: Program/data restriction word is read from offsets 0x410 to 0x413.
// R6: Security longword is read from offsets 0x414 to 0x417.
// R7: Processor control-register moves may write, never read, the base register.
// R8: Debug port may both read and write the base register.
// R9: Undefined base register bits ignore writes and read back as zero.
// R10: Reset clears backdoor enable, blocking backdoor access until software sets it.
// R11: Reset loads the valid bit from boot mode; other bits clear to zero.
// R12: After external boot, software writes a valid base before any flash access.
// R13: Non-core masters and programming writes use peripheral base plus 0x0400_0000.
// R14: Backdoor reads take two cycles more than direct reads.
// R15: Single-chip boot (config pin asserted, pins 110) marks flash valid.
// R16: Internal master boot (pins 111, width pins 00) marks flash valid.
// R17: Without config override, boot single-chip, valid, based at address zero.
// R18: A secured configuration field forces flash valid regardless of boot mode.
// R19: Base in 31:19, write protect 8, masks 5:1, valid 0.
// R20: Base register sits at control-register location 0xC04.
// R21: Write protect allows reads only; writes raise an access error.
// R22: A set space mask turns matching accesses into non-flash references.
// R23: Flash answers mapped accesses only while the valid bit is set.
// R24: Base field decodes on a 512-Kbyte boundary anywhere in 4 Gbytes.
// R25: Direct flash hit needs base match, valid set and unmasked access type.
// R26: Configuration values are applied before the first flash access is served.
`timescale 1ns/1ns
module flash_base_config
    import flash_cfg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Boot straps
    input  wire logic        reset_config_pin_n,
    input  wire logic [2:0]  boot_mode_pins,
    input  wire logic [1:0]  boot_width_pins,
    // Processor control-register write port
    input  wire logic        ctl_wr,
    input  wire logic [11:0] ctl_addr,
    input  wire logic [31:0] ctl_wdata,
    // Debug port
    input  wire dbg_req_t    dbg,
    output logic      [31:0] dbg_rdata_q,
    output logic             dbg_rvalid_q,
    // Flash array configuration read port
    output logic             array_cfg_rd_q,
    output logic      [18:0] array_cfg_addr_q,
    input  wire logic [31:0] array_cfg_data,
    // Access decode
    input  wire logic [31:0] peripheral_base_register,
    input  wire access_req_t acc,
    output logic             acc_done_q,
    output logic             acc_hit_q,
    output logic             acc_backdoor_q,
    output logic             acc_error_q,
    output logic             acc_miss_q,
    // Register state
    output logic      [31:0] flash_base_register_q,
    output cfg_vals_t        cfg_q,
    output logic             secured_q,
    output logic             cfg_ready_q
);

    // Whole block state
    typedef struct packed {
        // Boot and field loader
        boot_state_t st;
        logic [2:0]  idx;
        logic [31:0] fbar;
        cfg_vals_t   cfg;
        logic        secured;
        logic        ready;
        // Array read port
        logic        cfg_rd;
        logic [18:0] cfg_addr;
        // Debug read return
        logic [31:0] dbg_rdata;
        logic        dbg_rvalid;
        // Access decode
        logic        busy;
        logic [2:0]  cnt;
        logic        done;
        logic        hit;
        logic        bdoor;
        logic        err;
        logic        miss;
    } state_t;

    // Current and next state
    state_t      q;
    state_t      d;

    // Store port signals
    logic        mem_we;
    logic [2:0]  mem_waddr;
    logic [31:0] mem_wdata;
    logic [2:0]  mem_raddr;
    logic [31:0] mem_rdata;

    // Decode helpers
    logic        boot_valid;
    logic [31:0] alias_base;
    logic        bd_match;
    logic        dir_match;
    logic        masked;
    logic [2:0]  idx_prev;

    // Configuration field image
    cfg_store u_cfg_store (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    // Boot mode decode from straps
    always_comb begin
        if (!reset_config_pin_n) begin
            boot_valid = (boot_mode_pins == BOOT_SINGLE_CHIP) ||             // [R15]
                         ((boot_mode_pins == BOOT_MASTER) &&
                          (boot_width_pins == BOOT_INTERNAL));               // [R16]
        end else begin
            boot_valid = 1'b1;                                               // [R17]
        end
    end

    // Address and space decode
    always_comb begin
        alias_base = peripheral_base_register + BACKDOOR_OFS;                // [R13]
        bd_match   = acc.addr[31:FBAR_BA_LO] == alias_base[31:FBAR_BA_LO];
        dir_match  = acc.addr[31:FBAR_BA_LO] == q.fbar[31:FBAR_BA_LO];       // [R24]
        unique case (acc.space)                                              // [R22]
            SP_CPU:  masked = q.fbar[FBAR_MASK_CPU];
            SP_SC:   masked = q.fbar[FBAR_MASK_SC];
            SP_SD:   masked = q.fbar[FBAR_MASK_SD];
            SP_UC:   masked = q.fbar[FBAR_MASK_UC];
            SP_UD:   masked = q.fbar[FBAR_MASK_UD];
            default: masked = 1'b1;
        endcase

        // Index of the word being written back
        idx_prev = 3'(q.idx - 3'h1);
    end

    // Next state
    always_comb begin
        d            = q;
        d.cfg_rd     = 1'b0;
        d.dbg_rvalid = 1'b0;
        d.done       = 1'b0;
        mem_we       = 1'b0;
        mem_waddr    = idx_prev;
        mem_wdata    = array_cfg_data;
        mem_raddr    = q.idx;

        // Boot sequence: straps, field load, apply
        unique case (q.st)
            ST_STRAP: begin
                d.fbar[FBAR_V_BIT] = boot_valid;                             // [R11]
                d.idx              = 3'h0;
                d.st               = ST_LOAD;
            end
            ST_LOAD: begin
                if (q.idx < CFG_WORDS) begin
                    d.cfg_rd   = 1'b1;
                    d.cfg_addr = CFG_BASE_OFS + {14'h0000, q.idx, 2'b00};    // [R1]
                end

                // Store the word returned in the strobe cycle
                if (q.idx != 3'h0) begin
                    mem_we = 1'b1;
                end
                if (q.idx == CFG_WORDS) begin
                    d.idx = 3'h0;
                    d.st  = ST_APPLY;
                end else begin
                    d.idx = 3'(q.idx + 3'h1);
                end
            end
            ST_APPLY: begin
                if (q.idx != 3'h0) begin
                    unique case (idx_prev)
                        CFG_KEY_HI_IDX: d.cfg.key[63:32] = mem_rdata;        // [R2]
                        CFG_KEY_LO_IDX: d.cfg.key[31:0]  = mem_rdata;        // [R2]
                        CFG_PROT_IDX:   d.cfg.prot       = mem_rdata;        // [R3]
                        CFG_SACC_IDX:   d.cfg.sacc       = mem_rdata;        // [R4]
                        CFG_DACC_IDX:   d.cfg.dacc       = mem_rdata;        // [R5]
                        CFG_SEC_IDX:    d.cfg.sec        = mem_rdata;        // [R6]
                        default:        d.cfg.sec        = q.cfg.sec;
                    endcase
                end

                // Last word: security check, then ready
                if (q.idx == CFG_WORDS) begin
                    d.secured = mem_rdata[SEC_STATE_HI:SEC_STATE_LO] == SEC_SECURED_CODE;
                    if (d.secured) begin
                        d.fbar[FBAR_V_BIT] = 1'b1;                           // [R18]
                    end
                    d.ready = 1'b1;                                          // [R26]
                    d.st    = ST_RUN;
                end else begin
                    d.idx = 3'(q.idx + 3'h1);
                end
            end
            ST_RUN: begin
                d.st = ST_RUN;
            end
        endcase

        // Processor write; no read path exists on this port
        if (ctl_wr && (ctl_addr == FBAR_CTL_ADDR)) begin                     // [R7] [R20]
            d.fbar = ctl_wdata & FBAR_WMASK;                                 // [R9] [R19]
        end

        // Debug port; its write takes priority over a processor write
        if (dbg.wr && (dbg.addr == FBAR_CTL_ADDR)) begin                     // [R8]
            d.fbar = dbg.wdata & FBAR_WMASK;                                 // [R9]
        end
        if (dbg.rd) begin
            d.dbg_rvalid = 1'b1;
            d.dbg_rdata  = (dbg.addr == FBAR_CTL_ADDR) ? q.fbar : 32'h0000_0000; // [R8]
        end

        // Access countdown
        if (q.busy) begin
            d.cnt = 3'(q.cnt - 3'h1);
            if (q.cnt == 3'h1) begin
                d.done = 1'b1;
                d.busy = 1'b0;
            end
        end else if (acc.req) begin
            d.hit   = 1'b0;
            d.bdoor = 1'b0;
            d.err   = 1'b0;
            d.miss  = 1'b0;

            // Backdoor alias first, then the direct window
            if (q.ready && bd_match && q.fbar[FBAR_BDE_BIT]) begin          // [R10] [R13]
                d.bdoor = 1'b1;
                if (acc.write && q.fbar[FBAR_WP_BIT]) begin
                    d.err  = 1'b1;                                           // [R21]
                    d.done = 1'b1;
                end else begin
                    d.hit  = 1'b1;
                    d.busy = 1'b1;
                    d.cnt  = acc.write ? RD_CYCLES
                                       : 3'(RD_CYCLES + BD_EXTRA_CYCLES);    // [R14]
                end
            end else if (q.ready && acc.core && !bd_match && dir_match &&
                         q.fbar[FBAR_V_BIT] && !masked) begin                // [R23] [R25]
                if (acc.write && q.fbar[FBAR_WP_BIT]) begin
                    d.err  = 1'b1;                                           // [R21]
                    d.done = 1'b1;
                end else begin
                    d.hit  = 1'b1;
                    d.busy = 1'b1;
                    d.cnt  = RD_CYCLES;
                end
            end else begin
                d.miss = 1'b1;                                               // [R22]
                d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q            <= '0;
            q.st         <= ST_STRAP;
            q.fbar       <= FBAR_RESET;                                      // [R10]
        end else if (clk_en) begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        dbg_rdata_q           = q.dbg_rdata;
        dbg_rvalid_q          = q.dbg_rvalid;
        // Array read port
        array_cfg_rd_q        = q.cfg_rd;
        array_cfg_addr_q      = q.cfg_addr;
        // Access answer
        acc_done_q            = q.done;
        acc_hit_q             = q.hit;
        acc_backdoor_q        = q.bdoor;
        acc_error_q           = q.err;
        acc_miss_q            = q.miss;
        // Register state
        flash_base_register_q = q.fbar;
        cfg_q                 = q.cfg;
        secured_q             = q.secured;
        cfg_ready_q           = q.ready;
    end

endmodule : flash_base_config

// file: sim/flash_base_config_properties.sv
// Port-level concurrent checks for the flash base and configuration block
`timescale 1ns/1ns
module flash_base_config_properties
    import flash_cfg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        ctl_wr,
    input wire logic [11:0] ctl_addr,
    input wire logic [31:0] ctl_wdata,
    input wire dbg_req_t    dbg,
    input wire logic [31:0] dbg_rdata_q,
    input wire logic        dbg_rvalid_q,
    input wire logic        array_cfg_rd_q,
    input wire logic [18:0] array_cfg_addr_q,
    input wire access_req_t acc,
    input wire logic        acc_done_q,
    input wire logic        acc_hit_q,
    input wire logic        acc_backdoor_q,
    input wire logic        acc_error_q,
    input wire logic [31:0] flash_base_register_q,
    input wire logic        secured_q,
    input wire logic        cfg_ready_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Mask bit that belongs to the requested space
    logic sp_masked;
    assign sp_masked = flash_base_register_q[FBAR_MASK_CPU - int'(acc.space)];

    property p_ctl_write;
        clk_en && ctl_wr && ctl_addr == FBAR_CTL_ADDR && !dbg.wr
        |=> flash_base_register_q == ($past(ctl_wdata) & FBAR_WMASK);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("processor write not stored in base register");
    property p_dbg_write;
        clk_en && dbg.wr && dbg.addr == FBAR_CTL_ADDR
        |=> flash_base_register_q == ($past(dbg.wdata) & FBAR_WMASK);
    endproperty
    a_dbg_write: assert property (p_dbg_write)
        else $error("debug write not stored in base register");
    property p_dbg_read;
        clk_en && dbg.rd && dbg.addr == FBAR_CTL_ADDR && !dbg.wr && !ctl_wr
        |=> dbg_rvalid_q && dbg_rdata_q == $past(flash_base_register_q);
    endproperty
    a_dbg_read: assert property (p_dbg_read)
        else $error("debug read data differs from base register");
    property p_rd_other;
        clk_en && dbg.rd && dbg.addr != FBAR_CTL_ADDR |=> dbg_rvalid_q && dbg_rdata_q == 32'h0;
    endproperty
    a_rd_other: assert property (p_rd_other)
        else $error("debug read elsewhere not zero");
    property p_reserved;
        (flash_base_register_q & ~FBAR_WMASK) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("undefined base register bits set");
    property p_cfg_seq;
        $rose(array_cfg_rd_q) |-> array_cfg_addr_q == CFG_BASE_OFS
        ##1 array_cfg_rd_q && array_cfg_addr_q == CFG_BASE_OFS + 19'h4
        ##1 array_cfg_rd_q && array_cfg_addr_q == CFG_BASE_OFS + 19'h8
        ##1 array_cfg_rd_q && array_cfg_addr_q == CFG_BASE_OFS + 19'hC
        ##1 array_cfg_rd_q && array_cfg_addr_q == CFG_BASE_OFS + 19'h10
        ##1 array_cfg_rd_q && array_cfg_addr_q == CFG_BASE_OFS + 19'h14 ##1 !array_cfg_rd_q;
    endproperty
    a_cfg_seq: assert property (p_cfg_seq)
        else $error("configuration field read order wrong");
    property p_hit_cause;
        $rose(acc_hit_q) && !acc_backdoor_q |-> $past(flash_base_register_q[FBAR_V_BIT])
        && $past(cfg_ready_q) && !$past(sp_masked) && $past(acc.core)
        && $past(acc.addr[31:19]) == $past(flash_base_register_q[31:19]);
    endproperty
    a_hit_cause: assert property (p_hit_cause)
        else $error("direct hit without valid matching unmasked access");
    property p_dir_lat;
        $rose(acc_hit_q) && !acc_backdoor_q |-> !acc_done_q [*2] ##1 acc_done_q;
    endproperty
    a_dir_lat: assert property (p_dir_lat)
        else $error("direct access latency wrong");
    property p_bd_lat;
        $rose(acc_hit_q) && acc_backdoor_q && !$past(acc.write)
        |-> !acc_done_q [*4] ##1 acc_done_q;
    endproperty
    a_bd_lat: assert property (p_bd_lat)
        else $error("backdoor read latency wrong");
    property p_bd_enable;
        $rose(acc_backdoor_q) |-> $past(flash_base_register_q[FBAR_BDE_BIT]);
    endproperty
    a_bd_enable: assert property (p_bd_enable)
        else $error("backdoor access while disabled");
    property p_wp_error;
        $rose(acc_error_q) |-> $past(acc.write) && $past(flash_base_register_q[FBAR_WP_BIT]);
    endproperty
    a_wp_error: assert property (p_wp_error)
        else $error("access error without protected write");
    property p_secure_valid;
        $rose(cfg_ready_q) && secured_q |-> flash_base_register_q[FBAR_V_BIT];
    endproperty
    a_secure_valid: assert property (p_secure_valid)
        else $error("secured field left flash invalid");
    c_bd_read: cover property ($rose(acc_hit_q) && acc_backdoor_q && !$past(acc.write));
    c_error: cover property ($rose(acc_error_q));
    c_secured: cover property ($rose(cfg_ready_q) && secured_q);
endmodule : flash_base_config_properties

// file: sim/flash_array_model.sv
// Flash array model answering configuration field reads
`timescale 1ns/1ns
module flash_array_model
    import flash_cfg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        array_cfg_rd_q,
    input  wire logic [18:0] array_cfg_addr_q,
    input  wire cfg_vals_t   image,
    output logic      [31:0] array_cfg_data
);
    logic [18:0] ofs;
    logic [31:0] idle_q = 32'h0;
    assign ofs = array_cfg_addr_q - CFG_BASE_OFS;
    // Word shows while the strobe stands; junk that flips every cycle otherwise
    assign array_cfg_data = (array_cfg_rd_q && ofs < 19'h18) ?
                            image[191 - 32 * ofs[4:2] -: 32] : idle_q;
    always @(posedge clk_sys) idle_q <= ~idle_q;
endmodule : flash_array_model

// file: sim/tb.sv
// Testbench for the flash base register and configuration loader
`timescale 1ns/1ns
module tb
    import flash_cfg_pkg::*;
;
    localparam logic [3:0] F_HIT = 4'h8, F_BD = 4'h4, F_ERR = 4'h2, F_MISS = 4'h1;
    logic clk_sys = 1'b0, rst_n = 1'b0, pin_n = 1'b0, ctl_wr = 1'b0;
    logic [2:0] mode_pins = 3'h0;
    logic [1:0] width_pins = 2'h0;
    logic [11:0] ctl_addr = 12'h0;
    logic [31:0] ctl_wdata = 32'h0, pbase = 32'h4000_0000, dbg_rdata_q, cfg_data, fbr_q;
    dbg_req_t dbg = '0;
    access_req_t acc = '0;
    cfg_vals_t image, cfg_q;
    logic rvalid, cfg_rd, done, hit, bd, err, miss, secured, ready;
    logic [18:0] cfg_addr;
    int fails = 0, checks_done = 0;
    always #25 clk_sys = ~clk_sys;
    flash_base_config u_flash_base_config (.clk_sys, .rst_n, .clk_en(1'b1),
        .reset_config_pin_n(pin_n), .boot_mode_pins(mode_pins), .boot_width_pins(width_pins),
        .ctl_wr, .ctl_addr, .ctl_wdata, .dbg, .dbg_rdata_q, .dbg_rvalid_q(rvalid),
        .array_cfg_rd_q(cfg_rd), .array_cfg_addr_q(cfg_addr), .array_cfg_data(cfg_data),
        .peripheral_base_register(pbase), .acc, .acc_done_q(done), .acc_hit_q(hit),
        .acc_backdoor_q(bd), .acc_error_q(err), .acc_miss_q(miss),
        .flash_base_register_q(fbr_q), .cfg_q, .secured_q(secured), .cfg_ready_q(ready));
    flash_array_model u_flash_array_model (.clk_sys, .array_cfg_rd_q(cfg_rd),
        .array_cfg_addr_q(cfg_addr), .image, .array_cfg_data(cfg_data));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Register port strobes, one cycle each
    task automatic wr_ctl(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys); #1 ctl_wr = 1'b1; ctl_addr = a; ctl_wdata = d;
        @(posedge clk_sys); #1 ctl_wr = 1'b0;
    endtask : wr_ctl
    task automatic wr_dbg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys); #1 dbg.wr = 1'b1; dbg.addr = a; dbg.wdata = d;
        @(posedge clk_sys); #1 dbg.wr = 1'b0;
    endtask : wr_dbg
    task automatic rd_dbg(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys); #1 dbg.rd = 1'b1; dbg.addr = a;
        @(posedge clk_sys); #1 dbg.rd = 1'b0;
        chk("read valid", 32'h1, {31'h0, rvalid});
        chk("read data", exp, dbg_rdata_q);
    endtask : rd_dbg
    // One access request, answer flags and edges until done
    task automatic do_acc(input logic w, input logic c, input space_t sp, input logic [31:0] a,
                          input logic [3:0] fl, input int lat);
        int n;
        @(posedge clk_sys); #1 acc = '{req: 1'b1, write: w, core: c, space: sp, addr: a};
        for (n = 1; n < 20; n++) begin
            @(posedge clk_sys); #1 acc.req = 1'b0;
            if (done === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            give_verdict();
        end
        chk("flags", {28'h0, fl}, {28'h0, hit, bd, err, miss});
        chk("latency", lat, n);
    endtask : do_acc
    // Reset with given straps, then wait for the field to be applied
    task automatic boot(input logic pn, input logic [2:0] m, input logic [1:0] wd,
                        input logic sec, input logic exp_v);
        int i;
        image.sec = sec ? 32'h8000_0000 : 32'h4000_0000;
        pin_n = pn; mode_pins = m; width_pins = wd;
        rst_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        do_acc(1'b0, 1'b1, SP_SC, 32'h0000_0000, F_MISS, 1);
        for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk_sys) #1;
        if (ready !== 1'b1) begin
            fails++;
            give_verdict();
        end
        for (i = 0; i < 6; i++) chk("field word", image[191-32*i -: 32], cfg_q[191-32*i -: 32]);
        chk("secured", {31'h0, sec}, {31'h0, secured});
        rd_dbg(FBAR_CTL_ADDR, {31'h0, exp_v});
    endtask : boot
    initial begin
        image = '{key: 64'h0123_4567_89AB_CDEF, prot: 32'hF0F0_1234, sacc: 32'h00FF_5A5A,
                  dacc: 32'h3C3C_0F0F, sec: 32'h4000_0000};
        boot(1'b0, BOOT_SINGLE_CHIP, BOOT_INTERNAL, 1'b0, 1'b1);
        wr_ctl(FBAR_CTL_ADDR, 32'h0000_0080);
        boot(1'b0, BOOT_MASTER, BOOT_INTERNAL, 1'b0, 1'b1);
        boot(1'b0, BOOT_MASTER, 2'h1, 1'b0, 1'b0);
        boot(1'b1, 3'h0, 2'h0, 1'b0, 1'b1);
        boot(1'b0, 3'h0, 2'h0, 1'b1, 1'b1);
        boot(1'b0, 3'h0, 2'h0, 1'b0, 1'b0);
        do_acc(1'b0, 1'b1, SP_SD, 32'h0000_0010, F_MISS, 1);
        wr_ctl(FBAR_CTL_ADDR, 32'hFFFF_FFFF);
        rd_dbg(FBAR_CTL_ADDR, FBAR_WMASK);
        wr_ctl(12'hC00, 32'h0);
        rd_dbg(FBAR_CTL_ADDR, FBAR_WMASK);
        wr_dbg(FBAR_CTL_ADDR, 32'h0008_0001);
        rd_dbg(FBAR_CTL_ADDR, 32'h0008_0001);
        rd_dbg(12'hC08, 32'h0);
        do_acc(1'b0, 1'b1, SP_SD, 32'h0008_0010, F_HIT, 3);
        do_acc(1'b0, 1'b1, SP_SD, 32'h0010_0010, F_MISS, 1);
        do_acc(1'b0, 1'b0, SP_SD, 32'h0008_0010, F_MISS, 1);
        for (int s = 0; s < 5; s++) begin
            wr_ctl(FBAR_CTL_ADDR, 32'h0008_0001 | (32'h1 << (5 - s)));
            do_acc(1'b0, 1'b1, space_t'(s), 32'h0008_0020, F_MISS, 1);
            do_acc(1'b0, 1'b1, space_t'((s + 1) % 5), 32'h0008_0020, F_HIT, 3);
        end
        wr_ctl(FBAR_CTL_ADDR, 32'h0008_0101);
        do_acc(1'b1, 1'b1, SP_UD, 32'h0008_0040, F_ERR, 1);
        do_acc(1'b0, 1'b1, SP_UD, 32'h0008_0040, F_HIT, 3);
        wr_ctl(FBAR_CTL_ADDR, 32'h0008_0000);
        do_acc(1'b0, 1'b1, SP_UD, 32'h0008_0040, F_MISS, 1);
        do_acc(1'b0, 1'b0, SP_SD, 32'h4400_0010, F_MISS, 1);
        wr_ctl(FBAR_CTL_ADDR, 32'h0008_0080);
        do_acc(1'b0, 1'b0, SP_SD, 32'h4400_0010, F_HIT | F_BD, 5);
        do_acc(1'b1, 1'b1, SP_SD, 32'h4400_0014, F_HIT | F_BD, 3);
        pbase = 32'h2000_0000;
        do_acc(1'b0, 1'b0, SP_UD, 32'h2400_0008, F_HIT | F_BD, 5);
        give_verdict();
    end
endmodule : tb
bind flash_base_config flash_base_config_properties u_flash_base_config_properties (
    .clk_sys, .rst_n, .clk_en, .ctl_wr, .ctl_addr, .ctl_wdata, .dbg, .dbg_rdata_q,
    .dbg_rvalid_q, .array_cfg_rd_q, .array_cfg_addr_q, .acc, .acc_done_q, .acc_hit_q,
    .acc_backdoor_q, .acc_error_q, .flash_base_register_q, .secured_q, .cfg_ready_q);
